// ### sar_adc_pkg.sv
/*
 Package for the successive-approximation converter sequencer: register
 offsets, reset values, field layouts, sequencer states and shared helpers.
 Assumes a 100 MHz core clock and a plain address/strobe register port.
*/
package sar_adc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry and offsets
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam logic [2:0] OFS_MODE = 3'h0;
    localparam logic [2:0] OFS_CHSEL = 3'h1;
    localparam logic [2:0] OFS_PFMODE = 3'h2;
    localparam logic [2:0] OFS_THR = 3'h3;
    localparam logic [2:0] OFS_RESULT = 3'h4;
    localparam logic [2:0] OFS_RESULT_HI = 3'h5;
    localparam logic [2:0] OFS_STATUS = 3'h6;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and converter constants
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CHSEL_RST = 8'h00;
    localparam logic [7:0] PF_RST = 8'h00;
    localparam logic [7:0] THR_RST = 8'h00;
    localparam logic [9:0] RESULT_RST = 10'h000;
    localparam logic [9:0] SAR_MSB = 10'h200;
    localparam logic [3:0] SAR_TOP_BIT = 4'h9;
    localparam logic [5:0] RESULT_PAD = 6'h00;
    localparam logic [2:0] FIRST_CHAN = 3'h0;
    localparam logic [7:0] CNT_ZERO = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SAMPLE_TIME_NS = 200;
    localparam int SAMPLE_CYC = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SAMPLE_STEP = 8'h08;

    ////////////////////////////////////////////////////////////////////////
    // Register layouts
    typedef struct packed {
        logic conv_run;
        logic scan_enable;
        logic [2:0] conv_time_sel;
        logic speed_sel_hi;
        logic speed_sel_lo;
        logic ref_boost_on;
    } mode_reg_t;

    typedef struct packed {
        logic edge_sel_hi;
        logic edge_sel_lo;
        logic hw_trigger_sel;
        logic trigger_source_sel;
        logic zero_bit;
        logic [2:0] chan;
    } chsel_reg_t;

    typedef struct packed {
        logic powerfail_cmp_en;
        logic powerfail_cmp_dir;
        logic [5:0] zero_bits;
    } pf_reg_t;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_WAIT_TRIG,
        SEQ_SAMPLE,
        SEQ_CONVERT
    } seq_state_t;

    typedef struct packed {
        logic sync_a;
        logic sync_b;
        logic prev;
        logic rise;
        logic fall;
    } edge_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic is_high_speed(input mode_reg_t m);
        return m.speed_sel_hi ^ m.speed_sel_lo;
    endfunction

    function automatic logic pf_gate(input pf_reg_t p, input logic [7:0] hi, input logic [7:0] thr);
        if (!p.powerfail_cmp_en) begin
            return 1'b1;
        end
        return p.powerfail_cmp_dir ? (hi < thr) : (hi >= thr);
    endfunction

endpackage

// ### trig_edge_detect.sv
/*
 Trigger pin conditioner: two-stage synchroniser followed by a one-cycle
 rising and falling edge pulse. Assumes the pin may be asynchronous.
*/
module trig_edge_detect import sar_adc_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic rise,
    output logic fall
);

    edge_state_t st;
    edge_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Only sync_b and later stages feed the edge compare
    always_comb begin
        st_nxt = st;
        st_nxt.sync_a = pin;
        st_nxt.sync_b = st.sync_a;
        st_nxt.prev = st.sync_b;
        st_nxt.rise = st.sync_b & ~st.prev;
        st_nxt.fall = ~st.sync_b & st.prev;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= st_nxt;
        end
    end

    assign rise = st.rise;
    assign fall = st.fall;

endmodule

// ### sar_adc_sequencer.sv
/*
 Sequencer for a 10-bit successive-approximation converter: register port,
 trigger selection, select and scan channel stepping, bit search, result
 latch and power-fail gated end pulse.
 Assumes an external comparator answering cmp_above for the code on
 dac_code in the same cycle, and a one-cycle timer compare pulse.
*/
// Function
// - Software trigger: setting run starts conversions, repeated until run clears.
// - After hold, bit 9 trial-set and kept if input at least half reference.
// - Bits 8 down to 0 trial-set, kept if input at least the tap.
// - All ten bits decided: latch result and raise end pulse together.
// - Software mode, high speed: config write during conversion restarts it.
// - External mode: after run, wait for selected edge, convert once, wait.
// - High speed: a valid trigger during conversion restarts it.
// - Hardware modes, high speed: config write aborts, then wait for trigger.
// - Timer mode: each compare event converts once; retrigger restarts in high speed.
// - Select mode converts only the chosen channel, gated end pulse.
// - Scan mode converts channel 0 up to selected, pulse after each.
// - Scan with hardware trigger converts whole sequence once per trigger.
// - Aborted scan restarts at channel 0.
// - Compare disabled: end pulse after every conversion.
// - Compare enabled, direction 0: pulse only if high byte >= threshold.
// - Compare enabled, direction 1: pulse only if high byte < threshold.
// - Compare enabled: result still overwritten at every conversion end.
// - Edge field: 00 none, 01 falling, 10 rising, 11 both.
// - Channel field picks channel n, or range 0 to n in scan.
// - 16-bit view has result in upper ten bits; byte view upper eight.
// - Config write at conversion end wins: no latch and no pulse.
module sar_adc_sequencer import sar_adc_pkg::*; #(
    parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic ext_trigger_pin,
    input wire logic timer_compare_event,
    input wire logic cmp_above,
    output logic [9:0] dac_code,
    output logic [2:0] ana_chan,
    output logic sample_on,
    output logic ref_boost_on,
    output logic conv_end_irq
);

    typedef struct packed {
        seq_state_t state;
        logic [9:0] approx_reg;
        logic [3:0] bit_idx;
        logic [7:0] cnt;
        logic [2:0] chan;
        logic samp;
        logic [9:0] result_word;
        logic irq;
        logic [DATA_W-1:0] rdata;
        mode_reg_t mode;
        chsel_reg_t chsel;
        pf_reg_t pf;
        logic [7:0] thr;
    } core_state_t;

    localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_CYCLES - 1);

    core_state_t st_r;
    core_state_t st_nxt;
    logic rst_meta_r;
    logic rst_sync_r;
    logic edge_rise;
    logic edge_fall;
    logic cfg_wr;
    logic busy;
    logic trig;
    logic hs;
    logic conv_done;
    logic start;
    logic [2:0] start_chan;
    logic [9:0] final_code;
    logic [7:0] sample_last;
    mode_reg_t mode_new;
    chsel_reg_t chsel_new;

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    trig_edge_detect u_edge (
        .core_clk(core_clk),
        .rst_n(rst_sync_r),
        .pin(ext_trigger_pin),
        .rise(edge_rise),
        .fall(edge_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode and trigger selection
    assign cfg_wr = reg_wr && (reg_addr <= OFS_THR);
    assign busy = (st_r.state == SEQ_SAMPLE) || (st_r.state == SEQ_CONVERT);
    // Settings as they stand after this cycle's write
    assign mode_new = (reg_wr && reg_addr == OFS_MODE) ? mode_reg_t'(reg_wdata[7:0]) : st_r.mode;
    assign chsel_new = (reg_wr && reg_addr == OFS_CHSEL) ?
        chsel_reg_t'({reg_wdata[7:4], 1'b0, reg_wdata[2:0]}) : st_r.chsel;
    assign hs = is_high_speed(mode_new);
    assign conv_done = (st_r.state == SEQ_CONVERT) && (st_r.bit_idx == 4'h0);
    assign start_chan = mode_new.scan_enable ? FIRST_CHAN : chsel_new.chan;
    assign sample_last = SAMPLE_LAST + (SAMPLE_STEP * {5'h00, st_r.mode.conv_time_sel});

    always_comb begin
        trig = 1'b0;
        if (st_r.chsel.hw_trigger_sel) begin
            if (st_r.chsel.trigger_source_sel) begin
                trig = timer_compare_event;
            end else begin
                trig = (st_r.chsel.edge_sel_lo & edge_fall) | (st_r.chsel.edge_sel_hi & edge_rise);
            end
        end
    end

    always_comb begin
        final_code = st_r.approx_reg;
        final_code[0] = cmp_above;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        start = 1'b0;
        st_nxt.irq = 1'b0;
        st_nxt.rdata = '0;
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_MODE: st_nxt.mode = mode_new;
                OFS_CHSEL: st_nxt.chsel = chsel_new;
                OFS_PFMODE: st_nxt.pf = pf_reg_t'({reg_wdata[7:6], 6'h00});
                OFS_THR: st_nxt.thr = reg_wdata[7:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_MODE: st_nxt.rdata = {8'h00, st_r.mode};
                OFS_CHSEL: st_nxt.rdata = {8'h00, st_r.chsel};
                OFS_PFMODE: st_nxt.rdata = {8'h00, st_r.pf};
                OFS_THR: st_nxt.rdata = {8'h00, st_r.thr};
                OFS_RESULT: st_nxt.rdata = {st_r.result_word, RESULT_PAD};
                OFS_RESULT_HI: st_nxt.rdata = {8'h00, st_r.result_word[9:2]};
                OFS_STATUS: st_nxt.rdata = {11'h000, st_r.state, st_r.chan};
                default: st_nxt.rdata = '0;
            endcase
        end
        if (!st_nxt.mode.conv_run) begin
            st_nxt.state = SEQ_IDLE;
            st_nxt.samp = 1'b0;
        end else begin
            unique case (st_r.state)
                SEQ_IDLE, SEQ_WAIT_TRIG: begin
                    if (!st_nxt.chsel.hw_trigger_sel) begin
                        start = 1'b1;
                    end else if (st_r.state == SEQ_WAIT_TRIG && trig) begin
                        start = 1'b1;
                    end else begin
                        st_nxt.state = SEQ_WAIT_TRIG;
                    end
                end
                SEQ_SAMPLE, SEQ_CONVERT: begin
                    if (cfg_wr && hs) begin
                        if (st_nxt.chsel.hw_trigger_sel) begin
                            st_nxt.state = SEQ_WAIT_TRIG;
                            st_nxt.samp = 1'b0;
                        end else begin
                            start = 1'b1;
                        end
                    end else if (trig && hs) begin
                        start = 1'b1;
                    end else if (st_r.state == SEQ_SAMPLE) begin
                        if (st_r.cnt >= sample_last) begin
                            st_nxt.state = SEQ_CONVERT;
                            st_nxt.samp = 1'b0;
                            st_nxt.approx_reg = SAR_MSB;
                            st_nxt.bit_idx = SAR_TOP_BIT;
                        end else begin
                            st_nxt.cnt = st_r.cnt + 8'h01;
                        end
                    end else if (!conv_done) begin
                        st_nxt.approx_reg[st_r.bit_idx] = cmp_above;
                        st_nxt.approx_reg[st_r.bit_idx - 4'h1] = 1'b1;
                        st_nxt.bit_idx = st_r.bit_idx - 4'h1;
                    end else begin
                        st_nxt.approx_reg = final_code;
                        if (!cfg_wr) begin
                            st_nxt.result_word = final_code;
                            st_nxt.irq = pf_gate(st_r.pf, final_code[9:2], st_r.thr);
                        end
                        if (st_r.mode.scan_enable && st_r.chan < st_r.chsel.chan) begin
                            st_nxt.state = SEQ_SAMPLE;
                            st_nxt.chan = st_r.chan + 3'h1;
                            st_nxt.cnt = CNT_ZERO;
                            st_nxt.samp = 1'b1;
                        end else if (st_nxt.chsel.hw_trigger_sel) begin
                            st_nxt.state = SEQ_WAIT_TRIG;
                        end else begin
                            start = 1'b1;
                        end
                    end
                end
            endcase
        end
        if (start) begin
            st_nxt.state = SEQ_SAMPLE;
            st_nxt.chan = start_chan;
            st_nxt.cnt = CNT_ZERO;
            st_nxt.samp = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            st_r <= '{state: SEQ_IDLE, approx_reg: RESULT_RST, bit_idx: 4'h0, cnt: CNT_ZERO,
                      chan: FIRST_CHAN, samp: 1'b0, result_word: RESULT_RST, irq: 1'b0,
                      rdata: 16'h0000, mode: mode_reg_t'(MODE_RST), chsel: chsel_reg_t'(CHSEL_RST),
                      pf: pf_reg_t'(PF_RST), thr: THR_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign dac_code = st_r.approx_reg;
    assign ana_chan = st_r.chan;
    assign sample_on = st_r.samp;
    assign ref_boost_on = st_r.mode.ref_boost_on;
    assign conv_end_irq = st_r.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_r);

    property p_msb_trial;
        st_r.state == SEQ_SAMPLE && st_nxt.state == SEQ_CONVERT |=> dac_code == 10'h200 && st_r.bit_idx == 4'h9;
    endproperty
    a_msb_trial: assert property (p_msb_trial) else $error("msb trial not set on hold");

    property p_bit_decide;
        st_r.state == SEQ_CONVERT && st_nxt.state == SEQ_CONVERT && st_r.bit_idx != 4'h0
            |=> dac_code[$past(st_r.bit_idx)] == $past(cmp_above) && dac_code[$past(st_r.bit_idx) - 4'h1];
    endproperty
    a_bit_decide: assert property (p_bit_decide) else $error("bit decision wrong");

    property p_latch;
        conv_done && st_nxt.mode.conv_run && !cfg_wr && !(trig && hs)
            |=> st_r.result_word == $past(final_code) && conv_end_irq == pf_gate(st_r.pf, st_r.result_word[9:2], st_r.thr);
    endproperty
    a_latch: assert property (p_latch) else $error("result or end pulse missing");

    property p_write_wins;
        conv_done && cfg_wr |=> !conv_end_irq && $stable(st_r.result_word);
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("write at end did not win");

    property p_hw_abort;
        busy && cfg_wr && hs && st_nxt.mode.conv_run && st_nxt.chsel.hw_trigger_sel
            |=> st_r.state == SEQ_WAIT_TRIG && !sample_on;
    endproperty
    a_hw_abort: assert property (p_hw_abort) else $error("hardware abort not waiting");

    property p_retrig;
        busy && trig && hs && !cfg_wr && st_nxt.mode.conv_run
            |=> st_r.state == SEQ_SAMPLE && st_r.cnt == 8'h00 && ana_chan == (st_r.mode.scan_enable ? 3'h0 : st_r.chsel.chan);
    endproperty
    a_retrig: assert property (p_retrig) else $error("retrigger did not restart");

    property p_wait_hold;
        st_r.state == SEQ_WAIT_TRIG && !trig && !reg_wr |=> st_r.state == SEQ_WAIT_TRIG [*1];
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("left wait without trigger");

    property p_scan_step;
        conv_done && st_r.mode.scan_enable && st_r.chan < st_r.chsel.chan && !reg_wr && !trig
            |=> st_r.state == SEQ_SAMPLE && ana_chan == $past(st_r.chan) + 3'h1;
    endproperty
    a_scan_step: assert property (p_scan_step) else $error("scan did not advance");

    property p_sw_repeat;
        conv_done && !st_r.chsel.hw_trigger_sel && !reg_wr && st_r.mode.conv_run
            && !(st_r.mode.scan_enable && st_r.chan < st_r.chsel.chan)
            |=> st_r.state == SEQ_SAMPLE ##1 st_r.state == SEQ_SAMPLE;
    endproperty
    a_sw_repeat: assert property (p_sw_repeat) else $error("software mode did not repeat");

    property p_gate_ge;
        conv_done && !cfg_wr && st_r.pf.powerfail_cmp_en && !st_r.pf.powerfail_cmp_dir
            && final_code[9:2] < st_r.thr |=> !conv_end_irq;
    endproperty
    a_gate_ge: assert property (p_gate_ge) else $error("pulse despite compare below");

    property p_gate_lt;
        conv_done && !cfg_wr && st_r.pf.powerfail_cmp_en && st_r.pf.powerfail_cmp_dir
            && final_code[9:2] >= st_r.thr |=> !conv_end_irq;
    endproperty
    a_gate_lt: assert property (p_gate_lt) else $error("pulse despite compare not below");

    property p_sw_restart;
        busy && cfg_wr && hs && mode_new.conv_run && !chsel_new.hw_trigger_sel
            |=> st_r.state == SEQ_SAMPLE && st_r.cnt == CNT_ZERO && sample_on
            && ana_chan == (st_r.mode.scan_enable ? FIRST_CHAN : st_r.chsel.chan);
    endproperty
    a_sw_restart: assert property (p_sw_restart) else $error("software abort did not restart");

    property p_irq_plain;
        conv_done && !cfg_wr && !(trig && hs) && !st_r.pf.powerfail_cmp_en |=> conv_end_irq;
    endproperty
    a_irq_plain: assert property (p_irq_plain) else $error("ungated end pulse missing");

    property p_select_chan;
        sample_on && !st_r.mode.scan_enable && is_high_speed(st_r.mode) |-> ana_chan == st_r.chsel.chan;
    endproperty
    a_select_chan: assert property (p_select_chan) else $error("select mode on wrong channel");

    property p_scan_wrap;
        conv_done && st_r.mode.scan_enable && st_r.chan >= st_r.chsel.chan && !st_r.chsel.hw_trigger_sel
            && !reg_wr |=> sample_on && ana_chan == FIRST_CHAN;
    endproperty
    a_scan_wrap: assert property (p_scan_wrap) else $error("scan did not wrap to first channel");

    property p_timer_start;
        st_r.state == SEQ_WAIT_TRIG && st_r.chsel.hw_trigger_sel && st_r.chsel.trigger_source_sel
            && timer_compare_event && !reg_wr |=> st_r.state == SEQ_SAMPLE && sample_on;
    endproperty
    a_timer_start: assert property (p_timer_start) else $error("timer event did not start");

    property p_result_view;
        reg_rd && reg_addr == OFS_RESULT |=> reg_rdata == {$past(st_r.result_word), RESULT_PAD};
    endproperty
    a_result_view: assert property (p_result_view) else $error("result word view wrong");

endmodule

// ### sar_analog_model.sv
/*
 Analog front end stand-in: per-channel input levels, sample-and-hold and
 comparator. Assumes the sequencer samples while sample_on is high.
*/
module sar_analog_model (
    input wire logic core_clk,
    input wire logic [7:0][9:0] lvl,
    input wire logic [2:0] ana_chan,
    input wire logic sample_on,
    input wire logic [9:0] dac_code,
    output logic cmp_above
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] held_r = 10'h000;
    always_ff @(posedge core_clk) begin
        if (sample_on) begin
            held_r <= lvl[ana_chan];
        end
    end
    // Input at or above the trial tap keeps the bit
    assign cmp_above = (held_r >= dac_code);
endmodule

// ### sar_adc_sequencer_tb.sv
/*
 Self-checking bench for the converter sequencer: register tasks, trigger
 stimulus and result checks. Assumes the analog model answers the comparator.
*/
module sar_adc_sequencer_tb import sar_adc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int S = 2;
    localparam int LAT = S + 12;
    logic core_clk = 1'h0;
    logic rstn = 1'h0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic ext_trigger_pin = 1'h0;
    logic timer_compare_event = 1'h0;
    logic [DATA_W-1:0] reg_rdata;
    logic [9:0] dac_code;
    logic [2:0] ana_chan;
    logic cmp_above, sample_on, ref_boost_on, conv_end_irq;
    logic [7:0][9:0] lvl = {10'h0F0, 10'h3C1, 10'h055, 10'h2AA, 10'h200, 10'h3FF, 10'h13C, 10'h2A5};
    logic [7:0] pfv [4] = '{8'h80, 8'h80, 8'hC0, 8'hC0};
    logic [7:0] thv [4] = '{8'hAA, 8'hA9, 8'hA9, 8'hAA};
    logic [3:0] pfe = 4'hA;
    logic [15:0] d;
    int err_count = 0;
    int n_compared = 0;
    int n;

    sar_adc_sequencer #(.SAMPLE_CYCLES(S)) dut (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_trigger_pin(ext_trigger_pin),
        .timer_compare_event(timer_compare_event), .cmp_above(cmp_above), .dac_code(dac_code),
        .ana_chan(ana_chan), .sample_on(sample_on), .ref_boost_on(ref_boost_on), .conv_end_irq(conv_end_irq)
    );
    sar_analog_model afe (
        .core_clk(core_clk), .lvl(lvl), .ana_chan(ana_chan), .sample_on(sample_on),
        .dac_code(dac_code), .cmp_above(cmp_above)
    );

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic in_range(input int v, input int lo, input int hi);
        chk({15'h0000, v >= lo && v <= hi}, 16'h0001);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= {8'h00, v};
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 v = reg_rdata;
    endtask

    task automatic rc(input logic [2:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        chk(v, exp);
    endtask

    task automatic count_irq(input int k, output int c);
        c = 0;
        repeat (k) begin
            @(posedge core_clk);
            #1 c += (conv_end_irq === 1'h1);
        end
    endtask

    task automatic wait_irq(output int c);
        c = 0;
        do begin
            @(posedge core_clk);
            #1 c++;
        end while (conv_end_irq !== 1'h1 && c < 400);
        if (conv_end_irq !== 1'h1) begin
            err_count++;
            $display("Error at %0t: no end pulse", $time);
        end
    endtask

    task automatic pulse;
        @(posedge core_clk);
        timer_compare_event <= 1'h1;
        @(posedge core_clk);
        timer_compare_event <= 1'h0;
    endtask

    task automatic close_out;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge core_clk);
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'h1;
        repeat (3) @(posedge core_clk);
        for (int a = 0; a < 8; a++) begin
            rc(a[2:0], 16'h0000);
        end
        wr(OFS_CHSEL, 8'h0B);
        rc(OFS_CHSEL, 16'h0003);
        wr(OFS_RESULT, 8'hFF);
        rc(OFS_RESULT, 16'h0000);
        // Boost on in high-speed mode, then settle
        wr(OFS_MODE, 8'h03);
        #1 chk({15'h0000, ref_boost_on}, 16'h0001);
        repeat (100) @(posedge core_clk);
        wr(OFS_MODE, 8'h83);
        wait_irq(n);
        wait_irq(n);
        in_range(n, LAT - 3, LAT + 2);
        rc(OFS_RESULT, {lvl[3], 6'h00});
        rc(OFS_RESULT_HI, {8'h00, lvl[3][9:2]});
        wait_irq(n);
        repeat (5) @(posedge core_clk);
        wr(OFS_THR, 8'h00);
        wait_irq(n);
        in_range(n, LAT - 3, LAT + 2);
        wr(OFS_CHSEL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_PFMODE, pfv[i]);
            wr(OFS_THR, thv[i]);
            count_irq(3 * LAT, n);
            chk({15'h0000, n != 0}, {15'h0000, pfe[i]});
            rc(OFS_RESULT, {lvl[0], 6'h00});
        end
        wr(OFS_PFMODE, 8'h00);
        wr(OFS_CHSEL, 8'h02);
        wr(OFS_MODE, 8'hC3);
        for (int i = 0; i < 4; i++) begin
            wait_irq(n);
            rd(OFS_RESULT, d);
            chk(d, {lvl[i % 3], 6'h00});
        end
        wr(OFS_THR, 8'h00);
        wait_irq(n);
        rd(OFS_RESULT, d);
        chk(d, {lvl[0], 6'h00});
        wr(OFS_MODE, 8'h03);
        count_irq(2 * LAT, n);
        chk(n[15:0], 16'h0000);
        for (int e = 0; e < 4; e++) begin
            wr(OFS_CHSEL, {e[1:0], 6'h21});
            wr(OFS_MODE, 8'h83);
            count_irq(2 * LAT, n);
            chk(n[15:0], 16'h0000);
            @(posedge core_clk);
            ext_trigger_pin <= 1'h1;
            count_irq(3 * LAT, n);
            chk(n[15:0], {15'h0000, e[1]});
            @(posedge core_clk);
            ext_trigger_pin <= 1'h0;
            count_irq(3 * LAT, n);
            chk(n[15:0], {15'h0000, e[0]});
            wr(OFS_MODE, 8'h03);
        end
        rc(OFS_RESULT, {lvl[1], 6'h00});
        wr(OFS_CHSEL, 8'h31);
        wr(OFS_MODE, 8'h83);
        count_irq(2 * LAT, n);
        chk(n[15:0], 16'h0000);
        pulse();
        count_irq(3 * LAT, n);
        chk(n[15:0], 16'h0001);
        pulse();
        repeat (5) @(posedge core_clk);
        pulse();
        wait_irq(n);
        in_range(n, LAT - 3, LAT + 2);
        count_irq(2 * LAT, n);
        chk(n[15:0], 16'h0000);
        pulse();
        repeat (4) @(posedge core_clk);
        wr(OFS_THR, 8'h00);
        count_irq(3 * LAT, n);
        chk(n[15:0], 16'h0000);
        wr(OFS_MODE, 8'hC3);
        pulse();
        count_irq(4 * LAT, n);
        chk(n[15:0], 16'h0002);
        rc(OFS_RESULT, {lvl[1], 6'h00});
        wr(OFS_MODE, 8'h01);
        wr(OFS_MODE, 8'h00);
        #1 chk({15'h0000, ref_boost_on}, 16'h0000);
        close_out();
    end
endmodule
